// ### src/iias_pkg.sv
package iias_pkg;

  // ----------------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 50;
  localparam int CLK_GONE_NS = 1000;
  localparam int CLK_GONE_CYCLES = (CLK_GONE_NS * SYS_CLK_MHZ) / 1000;
  localparam int DATA_CLK_HALF = 4;
  localparam int CONV_CLK_HALF = 2;
  localparam int POLL_CYCLES = 64;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_ALARM = 5'h05;
  localparam logic [15:0] ALARM_RESET = 16'h0000;
  localparam logic [15:0] ALARM_IMPL_MASK = 16'hbfbc;
  localparam int BIT_ZEROCHK = 15;
  localparam int BIT_COLLIDE = 13;
  localparam int BIT_ONEAWAY = 12;
  localparam int BIT_TWOAWAY = 11;
  localparam int BIT_CONVGONE = 10;
  localparam int BIT_DATAGONE = 9;
  localparam int BIT_OUTGONE = 8;
  localparam int BIT_PATTERN = 7;
  localparam int BIT_PLL = 5;
  localparam int BIT_RPARITY = 4;
  localparam int BIT_FPARITY = 3;
  localparam int BIT_FRAMEPAR = 2;

  // ----------------------------------------------------------------
  // Data path constants
  // ----------------------------------------------------------------
  localparam logic [15:0] MIDSCALE = 16'h8000;
  localparam logic [7:0] WP_SYNC = 8'h01;
  localparam logic [7:0] RP_SYNC = 8'h10;
  localparam logic [2:0] LFV_OK_MIN = 3'h1;
  localparam logic [2:0] LFV_OK_MAX = 3'h6;

  // One-hot pointer to index; zero pointer maps to 0
  function automatic logic [2:0] ptr_index(input logic [7:0] ptr);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (ptr[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : ptr_index

endpackage : iias_pkg

// ### src/iias_if.sv
`timescale 1ns/100ps
`default_nettype none

interface iias_if;
  logic dataClk;
  logic convClk;
  logic [15:0] dataWord;
  logic parityBit;
  logic frameBit;
  logic syncReq;
  logic regWr;
  logic regRd;
  logic [4:0] regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic regRdValid;

  modport dev (
    input dataClk, convClk, dataWord, parityBit, frameBit, syncReq,
    input regWr, regRd, regAddr, regWdata,
    output regRdata, regRdValid
  );

  modport host (
    output dataClk, convClk, dataWord, parityBit, frameBit, syncReq,
    output regWr, regRd, regAddr, regWdata,
    input regRdata, regRdValid
  );
endinterface : iias_if

`default_nettype wire

// ### src/iias_clk_mon.sv
`timescale 1ns/100ps
`default_nettype none

module iias_clk_mon
  import iias_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkPin,
  output logic rise,
  output logic fall,
  output logic gone
);

  logic s1_q, s2_q, s3_q;
  logic [5:0] idleCnt_q;
  localparam logic [5:0] GONE_LIMIT = 6'(CLK_GONE_CYCLES);

  // ----------------------------------------------------------------
  // Synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1_q <= clkPin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise <= s2_q & ~s3_q;
      fall <= ~s2_q & s3_q;
    end
  end

  // ----------------------------------------------------------------
  // Loss timer
  // ----------------------------------------------------------------
  // Saturates so a dead clock keeps the gone level up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      idleCnt_q <= 6'h00;
      gone <= 1'b0;
    end else begin
      if (s2_q != s3_q) begin
        idleCnt_q <= 6'h00;
      end else if (idleCnt_q != GONE_LIMIT) begin
        idleCnt_q <= idleCnt_q + 6'h01;
      end
      gone <= (idleCnt_q == GONE_LIMIT);
    end
  end

endmodule : iias_clk_mon

`default_nettype wire

// ### src/iias_device.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R01 - All-zero write pointer sets bit 15
// R02 - Zero write pointer stays stuck until sync
// R03 - Controller resyncs FIFO on zero pointer alarm
// R04 - Bits 13:11 report collision, one-away, two-away
// R05 - Collision with shutoff: resync and clear
// R06 - Conversion clock stop sets bit 10
// R07 - Data clock stop sets bit 9
// R08 - Bit 8 set by clock loss or collision
// R09 - Bit 8 high forces midscale output samples
// R10 - Controller fixes faults, clears bits to resume
// R11 - Pattern mismatch sets bit 7
// R12 - Pattern mode: controller heeds only bit 7
// R13 - PLL lock loss sets bit 5
// R14 - Controller judges lock from loop filter voltage
// R15 - Rising-edge word parity error sets bit 4
// R16 - Falling-edge word parity error sets bit 3
// R17 - Frame-as-parity error sets bit 2
// R18 - Register at 0x05, write clears flags
// R19 - Flags sticky until software clears them
module iias_device
  import iias_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  iias_if.dev link,
  input wire logic pllLocked,
  input wire logic iotestEna,
  input wire logic [15:0] patRise,
  input wire logic [15:0] patFall,
  input wire logic frameParityEna,
  input wire logic convGoneEna,
  input wire logic dataGoneEna,
  input wire logic collideGoneEna,
  output logic [15:0] sampleOut,
  output logic outBlanked
);

  logic [15:0] wordS1_q, wordS2_q;
  logic parS1_q, parS2_q;
  logic frmS1_q, frmS2_q;
  logic pllS1_q, pllS2_q;
  logic dataRise, dataFall, dataGone;
  logic convRise, convGone;
  logic wordValid;
  logic [7:0] wp_q, rp_q;
  logic [2:0] wIdx, rIdx, ptrDiff;
  logic [15:0] fifoMem [8];
  logic collide, oneAway, twoAway;
  logic wordParErr, framePar;
  logic [15:0] alarm_q, alarm_d, alarmSet, alarmClr;
  logic [15:0] regRdata_q;
  logic regRdValid_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Data settles well inside a half period, so two flops align it
  // with the synchronised clock edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wordS1_q <= 16'h0000;
      wordS2_q <= 16'h0000;
      parS1_q <= 1'b0;
      parS2_q <= 1'b0;
      frmS1_q <= 1'b0;
      frmS2_q <= 1'b0;
      pllS1_q <= 1'b0;
      pllS2_q <= 1'b0;
    end else begin
      wordS1_q <= link.dataWord;
      wordS2_q <= wordS1_q;
      parS1_q <= link.parityBit;
      parS2_q <= parS1_q;
      frmS1_q <= link.frameBit;
      frmS2_q <= frmS1_q;
      pllS1_q <= pllLocked;
      pllS2_q <= pllS1_q;
    end
  end

  // ----------------------------------------------------------------
  // Clock monitors
  // ----------------------------------------------------------------
  iias_clk_mon uDataMon (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkPin(link.dataClk),
    .rise(dataRise),
    .fall(dataFall),
    .gone(dataGone)
  );

  iias_clk_mon uConvMon (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkPin(link.convClk),
    .rise(convRise),
    .fall(),
    .gone(convGone)
  );

  assign wordValid = dataRise | dataFall;

  // ----------------------------------------------------------------
  // FIFO pointers
  // ----------------------------------------------------------------
  // Reset leaves both pointers empty: a missing start-up sync shows
  // up as the zero pointer alarm instead of silent garbage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wp_q <= 8'h00;
    end else if (link.syncReq) begin
      wp_q <= WP_SYNC;
    end else if (wordValid && wp_q != 8'h00) begin // R02
      wp_q <= {wp_q[6:0], wp_q[7]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rp_q <= 8'h00;
    end else if (link.syncReq) begin
      rp_q <= RP_SYNC;
    end else if (convRise && rp_q != 8'h00) begin
      rp_q <= {rp_q[6:0], rp_q[7]};
    end
  end

  assign wIdx = ptr_index(wp_q);
  assign rIdx = ptr_index(rp_q);
  assign ptrDiff = wIdx - rIdx;

  // ----------------------------------------------------------------
  // FIFO storage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (wordValid && wp_q != 8'h00) begin // R02
      fifoMem[wIdx] <= wordS2_q;
    end
  end

  // ----------------------------------------------------------------
  // Alarm conditions
  // ----------------------------------------------------------------
  always_comb begin
    collide = 1'b0;
    oneAway = 1'b0;
    twoAway = 1'b0;
    if (wp_q != 8'h00 && rp_q != 8'h00) begin
      collide = (ptrDiff == 3'h0); // R04
      oneAway = (ptrDiff == 3'h1) || (ptrDiff == 3'h7); // R04
      twoAway = (ptrDiff == 3'h2) || (ptrDiff == 3'h6); // R04
    end
  end

  // Even parity over the captured word
  assign wordParErr = (^wordS2_q) != parS2_q;
  assign framePar = frameParityEna && dataRise && ((^wordS2_q) != frmS2_q);

  always_comb begin
    alarmSet = 16'h0000;
    alarmSet[BIT_ZEROCHK] = (wp_q == 8'h00); // R01
    alarmSet[BIT_COLLIDE] = collide; // R04
    alarmSet[BIT_ONEAWAY] = oneAway; // R04
    alarmSet[BIT_TWOAWAY] = twoAway; // R04
    alarmSet[BIT_CONVGONE] = convGone; // R06
    alarmSet[BIT_DATAGONE] = dataGone; // R07
    alarmSet[BIT_OUTGONE] = (convGone && convGoneEna) // R08
      || (dataGone && dataGoneEna)
      || (collide && collideGoneEna);
    alarmSet[BIT_PATTERN] = iotestEna // R11
      && ((dataRise && wordS2_q != patRise)
      || (dataFall && wordS2_q != patFall));
    alarmSet[BIT_PLL] = ~pllS2_q; // R13
    alarmSet[BIT_RPARITY] = dataRise && wordParErr; // R15
    alarmSet[BIT_FPARITY] = dataFall && wordParErr; // R16
    alarmSet[BIT_FRAMEPAR] = framePar; // R17
  end

  // ----------------------------------------------------------------
  // Alarm status register
  // ----------------------------------------------------------------
  // Writing a one clears that flag; a set in the same cycle wins
  assign alarmClr = (link.regWr && link.regAddr == ADDR_ALARM)
    ? (link.regWdata & ALARM_IMPL_MASK) : 16'h0000; // R18
  assign alarm_d = ((alarm_q & ~alarmClr) | alarmSet)
    & ALARM_IMPL_MASK; // R19

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alarm_q <= ALARM_RESET; // R18
    end else begin
      alarm_q <= alarm_d; // R19
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdValid_q <= 1'b0;
      regRdata_q <= 16'h0000;
    end else begin
      regRdValid_q <= link.regRd;
      if (link.regRd && link.regAddr == ADDR_ALARM) begin
        regRdata_q <= alarm_q; // R18
      end else begin
        regRdata_q <= 16'h0000;
      end
    end
  end

  assign link.regRdata = regRdata_q;
  assign link.regRdValid = regRdValid_q;

  // ----------------------------------------------------------------
  // Output samples
  // ----------------------------------------------------------------
  // Blanking follows the flag without waiting for a conversion edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sampleOut <= MIDSCALE;
      outBlanked <= 1'b0;
    end else begin
      outBlanked <= alarm_d[BIT_OUTGONE]; // R09
      if (alarm_d[BIT_OUTGONE]) begin
        sampleOut <= MIDSCALE; // R09
      end else if (convRise) begin
        sampleOut <= (rp_q != 8'h00) ? fifoMem[rIdx] : MIDSCALE;
      end
    end
  end

endmodule : iias_device

`default_nettype wire

// ### src/iias_host.sv
`timescale 1ns/100ps
`default_nettype none

module iias_host
  import iias_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  iias_if.host link,
  input wire logic stopDataClk,
  input wire logic stopConvClk,
  input wire logic flipParity,
  input wire logic iotestEna,
  input wire logic collideGoneEna,
  input wire logic [2:0] lfVolt,
  output logic [15:0] alarmView,
  output logic pllOk,
  output logic resyncDone
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_READ = 3'b001,
    H_WAIT = 3'b010,
    H_SYNC = 3'b011,
    H_CLEAR = 3'b100
  } iias_hstate_e;

  iias_hstate_e state_q;
  logic [1:0] dataDiv_q, convDiv_q;
  logic dataClk_q, convClk_q, parity_q;
  logic [15:0] word_q, seen_q, wdata_q;
  logic [6:0] pollCnt_q;
  logic rd_q, wr_q, sync_q;
  logic [2:0] lfS1_q, lfS2_q;
  logic [15:0] nextWord;

  // ----------------------------------------------------------------
  // Link clocks and data stream
  // ----------------------------------------------------------------
  assign nextWord = word_q + 16'h0001;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dataDiv_q <= 2'h0;
      dataClk_q <= 1'b0;
      word_q <= 16'h0000;
      parity_q <= 1'b0;
    end else if (!stopDataClk) begin
      dataDiv_q <= dataDiv_q + 2'h1;
      if (dataDiv_q == 2'(DATA_CLK_HALF - 1)) begin
        dataDiv_q <= 2'h0;
        dataClk_q <= ~dataClk_q;
        word_q <= nextWord;
        parity_q <= (^nextWord) ^ flipParity;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      convDiv_q <= 2'h0;
      convClk_q <= 1'b0;
    end else if (!stopConvClk) begin
      convDiv_q <= convDiv_q + 2'h1;
      if (convDiv_q == 2'(CONV_CLK_HALF - 1)) begin
        convDiv_q <= 2'h0;
        convClk_q <= ~convClk_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // PLL lock judged from loop filter voltage
  // ----------------------------------------------------------------
  // The lock flag is not trusted on early parts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lfS1_q <= 3'h0;
      lfS2_q <= 3'h0;
      pllOk <= 1'b0;
    end else begin
      lfS1_q <= lfVolt;
      lfS2_q <= lfS1_q;
      pllOk <= (lfS2_q >= LFV_OK_MIN) && (lfS2_q <= LFV_OK_MAX); // R14
    end
  end

  // ----------------------------------------------------------------
  // Poll, recover and clear
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= H_IDLE;
      pollCnt_q <= 7'h00;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      sync_q <= 1'b0;
      seen_q <= 16'h0000;
      wdata_q <= 16'h0000;
      alarmView <= 16'h0000;
      resyncDone <= 1'b0;
    end else begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      sync_q <= 1'b0;
      resyncDone <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          pollCnt_q <= pollCnt_q + 7'h01;
          if (pollCnt_q == 7'(POLL_CYCLES - 1)) begin
            pollCnt_q <= 7'h00;
            rd_q <= 1'b1;
            state_q <= H_READ;
          end
        end
        H_READ: begin
          state_q <= H_WAIT;
        end
        H_WAIT: begin
          if (link.regRdValid) begin
            if (iotestEna) begin
              seen_q <= link.regRdata & (16'h0001 << BIT_PATTERN); // R12
              alarmView <= link.regRdata & (16'h0001 << BIT_PATTERN);
              state_q <= H_CLEAR;
            end else begin
              seen_q <= link.regRdata;
              alarmView <= link.regRdata;
              if (link.regRdata[BIT_ZEROCHK] // R03
                  || (link.regRdata[BIT_COLLIDE] && collideGoneEna)) begin
                state_q <= H_SYNC; // R05
              end else begin
                state_q <= H_CLEAR; // R10
              end
            end
          end
        end
        H_SYNC: begin
          sync_q <= 1'b1; // R03
          resyncDone <= 1'b1;
          state_q <= H_CLEAR;
        end
        H_CLEAR: begin
          // Clears only what was seen; a live fault sets it again
          wr_q <= (seen_q != 16'h0000);
          wdata_q <= seen_q; // R10
          state_q <= H_IDLE;
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  assign link.dataClk = dataClk_q;
  assign link.convClk = convClk_q;
  assign link.dataWord = word_q;
  assign link.parityBit = parity_q;
  assign link.frameBit = parity_q;
  assign link.syncReq = sync_q;
  assign link.regRd = rd_q;
  assign link.regWr = wr_q;
  assign link.regAddr = ADDR_ALARM;
  assign link.regWdata = wdata_q;

endmodule : iias_host

`default_nettype wire

// ### bench/iias_props.sv
`timescale 1ns/100ps
`default_nettype none

module iias_props
  import iias_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dataClk,
  input wire logic convClk,
  input wire logic [15:0] dataWord,
  input wire logic parityBit,
  input wire logic frameBit,
  input wire logic syncReq,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regRdata,
  input wire logic regRdValid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  rd_answer_a: assert property (regRd |=> regRdValid)
    else $error("read not answered one cycle later");
  rd_cause_a: assert property (regRdValid |-> $past(regRd))
    else $error("read valid without a read strobe");
  rd_idle_a: assert property (!regRdValid |-> regRdata == 16'h0000)
    else $error("read data not zero outside valid");
  rsvd_zero_a: assert property (regRdValid |->
    (regRdata[14] == 1'b0 && regRdata[6] == 1'b0 && regRdata[1:0] == 2'h0))
    else $error("reserved status bit reads one");
  wr_addr_a: assert property (regWr |-> regAddr == ADDR_ALARM)
    else $error("write to a place other than the status register");

  // ----------------------------------------------------------------
  // Resync handling on the far side
  // ----------------------------------------------------------------
  // Host reacts within its loop, well before the next poll
  zero_resync_a: assert property (regRdValid && regRdata[15] |->
    ##[1:8] syncReq)
    else $error("zero pointer alarm not followed by resync");
  // Clear write follows the resync pulse in the very next cycle
  sync_pulse_a: assert property (syncReq |=> (!syncReq && regWr))
    else $error("resync not a single pulse followed by a clear");

  // ----------------------------------------------------------------
  // Wire behaviour
  // ----------------------------------------------------------------
  frame_par_a: assert property (frameBit == parityBit)
    else $error("frame bit differs from parity bit");
  dclk_half_a: assert property ($changed(dataClk) |=>
    $stable(dataClk) [*3])
    else $error("data clock half period too short");
  word_edge_a: assert property ($changed(dataWord) |->
    $changed(dataClk))
    else $error("data word changed away from a clock edge");
  cclk_half_a: assert property ($changed(convClk) |=> $stable(convClk))
    else $error("conversion clock half period too short");
endmodule : iias_props

`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench
  import iias_pkg::*;
;
  logic sys_clk, rst_n, pllLocked, iotestEna, frameParityEna;
  logic convGoneEna, dataGoneEna, collideGoneEna;
  logic stopDataClk, stopConvClk, flipParity;
  logic [15:0] patRise, patFall, sampleOut, alarmView, v;
  logic [2:0] lfVolt;
  logic outBlanked, pllOk;
  int failures, checked;
  logic [2:0] lfTab [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
  logic lfExp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  iias_if lnk();

  iias_device iias_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(lnk),
    .pllLocked(pllLocked), .iotestEna(iotestEna), .patRise(patRise),
    .patFall(patFall), .frameParityEna(frameParityEna),
    .convGoneEna(convGoneEna), .dataGoneEna(dataGoneEna),
    .collideGoneEna(collideGoneEna), .sampleOut(sampleOut),
    .outBlanked(outBlanked));

  iias_host iias_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(lnk),
    .stopDataClk(stopDataClk), .stopConvClk(stopConvClk),
    .flipParity(flipParity), .iotestEna(iotestEna),
    .collideGoneEna(collideGoneEna), .lfVolt(lfVolt),
    .alarmView(alarmView), .pllOk(pllOk), .resyncDone());

  iias_props iias_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .dataClk(lnk.dataClk), .convClk(lnk.convClk), .dataWord(lnk.dataWord),
    .parityBit(lnk.parityBit), .frameBit(lnk.frameBit),
    .syncReq(lnk.syncReq), .regWr(lnk.regWr), .regRd(lnk.regRd),
    .regAddr(lnk.regAddr), .regRdata(lnk.regRdata),
    .regRdValid(lnk.regRdValid));

  always #10 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compares %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Passive read: the host owns the port, so catch its next answer
  task automatic rd(output logic [15:0] val);
    int n;
    n = 0;
    @(posedge sys_clk);
    while (lnk.regRdValid !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) begin
      failures++;
    end
    val = lnk.regRdata;
  endtask : rd

  // Host clears what it saw; give it a bounded number of polls
  task automatic settle(input logic [15:0] m);
    int n;
    logic [15:0] val;
    n = 0;
    rd(val);
    while ((val & m) !== 16'h0000 && n < 12) begin
      rd(val);
      n++;
    end
    chk(val & m, 16'h0000);
  endtask : settle

  task automatic clk_loss(input logic conv, input logic [15:0] m);
    rd(v);
    if (conv) begin
      stopConvClk <= 1'b1;
    end else begin
      stopDataClk <= 1'b1;
    end
    repeat (80) @(posedge sys_clk);
    chk({15'h0000, outBlanked}, 16'h0001);
    chk(sampleOut, MIDSCALE);
    rd(v);
    chk(v & m, m);
    stopConvClk <= 1'b0;
    stopDataClk <= 1'b0;
    settle(m);
    repeat (8) @(posedge sys_clk);
    chk({15'h0000, outBlanked}, 16'h0000);
  endtask : clk_loss

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    pllLocked = 1'b1;
    iotestEna = 1'b0;
    patRise = 16'h0000;
    patFall = 16'h0000;
    frameParityEna = 1'b1;
    convGoneEna = 1'b1;
    dataGoneEna = 1'b1;
    collideGoneEna = 1'b1;
    stopDataClk = 1'b0;
    stopConvClk = 1'b0;
    flipParity = 1'b0;
    lfVolt = 3'h3;
    failures = 0;
    checked = 0;
    repeat (5) @(posedge sys_clk);
    chk(sampleOut, MIDSCALE);
    chk(lnk.regRdata, 16'h0000);
    rst_n <= 1'b1;
    // Empty pointers after reset must raise the zero pointer alarm
    rd(v);
    chk(v & 16'h8000, 16'h8000);
    settle(ALARM_IMPL_MASK);
    chk({15'h0000, outBlanked}, 16'h0000);
    // Short parity burst well between polls, gone before the next read
    rd(v);
    repeat (20) @(posedge sys_clk);
    flipParity <= 1'b1;
    repeat (16) @(posedge sys_clk);
    flipParity <= 1'b0;
    rd(v);
    chk(v & 16'h001c, 16'h001c);
    settle(16'h001c);
    // Lock loss glitch
    rd(v);
    repeat (20) @(posedge sys_clk);
    pllLocked <= 1'b0;
    repeat (16) @(posedge sys_clk);
    pllLocked <= 1'b1;
    rd(v);
    chk(v & 16'h0020, 16'h0020);
    settle(16'h0020);
    for (int i = 0; i < 4; i++) begin
      lfVolt <= lfTab[i];
      repeat (8) @(posedge sys_clk);
      chk({15'h0000, pllOk}, {15'h0000, lfExp[i]});
    end
    // A frozen clock stalls one pointer, so the pointers must collide
    clk_loss(1'b0, 16'h2300);
    clk_loss(1'b1, 16'h2500);
    // Pattern mode: patterns of zero never match the live stream
    iotestEna <= 1'b1;
    rd(v);
    rd(v);
    chk(v & 16'h0080, 16'h0080);
    repeat (3) @(posedge sys_clk);
    chk(alarmView & 16'hff7f, 16'h0000);
    iotestEna <= 1'b0;
    settle(ALARM_IMPL_MASK);
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule : testbench

`default_nettype wire
